//--- hw/rsc_reset_sleep_control.sv
`timescale 1ns/1ps
`include "rsc_consts.svh"
// Contract
// [R1] sleep entered only with sleep enable set
// [R2] software sets sleep enable just before sleep
// [R3] mode field at bits 4:3 and 2
// [R4] codes 0-3 modes, 4-5 reserved, 6 standby
// [R5] code 7 is extended standby, crystal only
// [R6] standby modes need external crystal clock option
// [R7] debug fuse keeps clock in power-down/save
// [R8] disable bit or unset fuse kills scan port
// [R9] scan data output floats when not shifting
// [R10] reset loads registers, then start at vector
// [R11] ports forced to init asynchronously on reset
// [R12] stretch counter holds reset after sources release
// [R13] five sources assert the internal reset
// [R14] pin reset works clockless, then stretches
// [R15] power loss reasserts reset immediately
// [R16] reset held while scan reset register set
// [R17] watchdog reset only when enabled and expired
// [R18] one-cycle watchdog pulse; count from its end
// [R19] brown-out with fuse resets immediately, stretches
// [R20] reference on for brown-out, bandgap, or converter
// [R21] software waits reference start-up before use
// [R22] per-source flags, write zero clears, power clears
// [R23] sleep without enable just continues
// [R24] any source reasserting restarts the stretch count
module rsc_reset_sleep_control
#(
    parameter int STRETCH_LONG  = `RSC_STRETCH_CYC_LONG,
    parameter int STRETCH_SHORT = `RSC_STRETCH_CYC_SHORT
)
(
    // clock and supply-level reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // reset sources
    input  wire logic       extResetN,
    input  wire logic       wdtExpire,
    input  wire logic       wdtEnable,
    input  wire logic       brownoutLow,
    input  wire logic       scanResetReg,
    // fuses
    input  wire logic       brownoutOnFuse,
    input  wire logic [3:0] clockOptionFuses,
    input  wire logic       debugKeepClockFuse,
    input  wire logic       scanPortFuse,
    // core register access
    input  wire logic [5:0] ioAddr,
    input  wire logic       ioWrite,
    input  wire logic       ioRead,
    input  wire logic [7:0] ioWdata,
    output logic      [7:0] ioRdata,
    input  wire logic       sleepExec,
    // analog enables
    input  wire logic       comparatorBandgapSelect,
    input  wire logic       adcEnable,
    // scan port
    input  wire logic       scanShifting,
    input  wire logic       scanTdoData,
    output logic            scanTdoOut,
    output logic            scanTdoOeN,
    output logic            scanPortEnable,
    // results
    output logic            coreResetN,
    output logic            portInitN,
    output logic            sleeping,
    output logic      [2:0] sleepMode,
    output logic            mainClockKeep,
    output logic            referenceOn
);
    rsc_src_if srcBus ();

    rsc_src_combine uSrc
    (
        .powerLowN      (resetn),
        .extResetN      (extResetN),
        .wdtExpire      (wdtExpire),
        .wdtEnable      (wdtEnable),
        .brownoutLow    (brownoutLow),
        .brownoutOnFuse (brownoutOnFuse),
        .scanResetReg   (scanResetReg),
        .src            (srcBus)
    );

    // asynchronous reset from all non-clocked sources; watchdog is a synchronous pulse
    wire asyncSrcN = resetn & extResetN & ~(brownoutLow & brownoutOnFuse) & ~scanResetReg; // [R11] [R14] [R15] [R16] [R19]

    function automatic logic isXtal(input logic [3:0] opt);
        isXtal = (opt >= `RSC_XTAL_MIN_CODE);
    endfunction

    // registers
    logic [7:0]             pmc_q;
    logic [7:0]             rsr_q;
    logic [31:0]            cnt_q;
    logic [31:0]            cnt_d;
    rsc_pkg::rsc_rst_state_t st_q;
    rsc_pkg::rsc_rst_state_t st_d;
    logic                   portInit_q;
    logic                   sleep_q;
    logic [2:0]             mode_q;
    logic                   keep_q;
    logic                   ref_q;
    logic                   tdoOut_q;
    logic                   tdoOeN_q;
    logic                   spEn_q;
    logic [7:0]             rdata_q;

    // field decode
    wire       pmcHit   = (ioAddr == `RSC_PMC_ADDR);
    wire       rsrHit   = (ioAddr == `RSC_RSR_ADDR);
    wire       sleepEn  = pmc_q[`RSC_PMC_SE_BIT];
    wire [2:0] modeSel  = {pmc_q[`RSC_PMC_SMHI_BIT],
                           pmc_q[`RSC_PMC_SMLO_HI:`RSC_PMC_SMLO_LO]};        // [R3]
    wire       xtal     = isXtal(clockOptionFuses);
    wire       modeOk   = (modeSel != rsc_pkg::RSC_SM_RSV4) &&
                          (modeSel != rsc_pkg::RSC_SM_RSV5) &&
                          (modeSel[2:1] != 2'b11 || xtal);               // [R4] [R5] [R6]
    wire       enterSlp = sleepExec & sleepEn & modeOk;                  // [R1] [R23]
    // judged on the latched mode, so a later field write cannot move it
    wire       deepMode = (mode_q == rsc_pkg::RSC_SM_PDOWN) ||
                          (mode_q == rsc_pkg::RSC_SM_PSAVE);
    wire       keepNext = sleeping ? (deepMode & debugKeepClockFuse) : 1'b0; // [R7]
    wire       spEnNext = scanPortFuse & ~rsr_q[`RSC_RSR_SPD_BIT];        // [R8]
    wire       wakeAny  = srcBus.anySrc;
    wire [31:0] stretch = xtal ? STRETCH_LONG : STRETCH_SHORT;            // [R12]

    // reset stretch sequencer
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            rsc_pkg::RSC_ST_HOLD:
            begin
                cnt_d = 32'h0000_0000;
                if (!wakeAny)
                    st_d = rsc_pkg::RSC_ST_STRETCH;                     // [R18]
            end
            rsc_pkg::RSC_ST_STRETCH:
            begin
                cnt_d = cnt_q + 32'h0000_0001;
                if (wakeAny)
                    st_d = rsc_pkg::RSC_ST_HOLD;                        // [R24]
                else if (cnt_q + 32'h0000_0001 >= stretch)
                    st_d = rsc_pkg::RSC_ST_RUN;                         // [R12]
            end
            rsc_pkg::RSC_ST_RUN:
            begin
                if (wakeAny)
                    st_d = rsc_pkg::RSC_ST_HOLD;                        // [R13] [R17]
            end
            default:
                st_d = rsc_pkg::RSC_ST_HOLD;
        endcase
    end

    always_ff @(posedge clk or negedge asyncSrcN)
    begin
        if (!asyncSrcN)
        begin
            st_q       <= rsc_pkg::RSC_ST_HOLD;
            cnt_q      <= 32'h0000_0000;
            portInit_q <= 1'b0;                                         // [R11]
        end
        else
        begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            portInit_q <= (st_d == rsc_pkg::RSC_ST_RUN);
        end
    end

    wire coreRun = (st_q == rsc_pkg::RSC_ST_RUN);

    // control register: cleared while internal reset stands
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pmc_q <= `RSC_PMC_RESET;
        else if (!coreRun)
            pmc_q <= `RSC_PMC_RESET;                                    // [R10]
        else if (ioWrite && pmcHit)
            pmc_q <= ioWdata & `RSC_PMC_WMASK;
    end

    // status flags: hardware set beats software clear
    wire [4:0] hit = srcBus.srcHit;
    logic [7:0] rsr_d;
    always_comb
    begin
        rsr_d = rsr_q;
        if (ioWrite && rsrHit && coreRun)
            rsr_d = {ioWdata[7], 2'b00, rsr_q[4:0] & ioWdata[4:0]};     // [R22]
        rsr_d[4:0] = rsr_d[4:0] | {hit[4], hit[3], hit[2], hit[1], 1'b0};
    end

    // power-on clears the other flags and sets its own
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rsr_q <= `RSC_RSR_RESET;                                    // [R22]
        else
            rsr_q <= rsr_d;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sleep_q <= 1'b0;
            mode_q  <= 3'h0;
        end
        else if (!coreRun || wakeAny)
            sleep_q <= 1'b0;
        else if (enterSlp)
        begin
            sleep_q <= 1'b1;                                            // [R1]
            mode_q  <= modeSel;
        end
    end

    // scan port, reference and read data
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            keep_q   <= 1'b0;
            ref_q    <= 1'b0;
            tdoOut_q <= 1'b0;
            tdoOeN_q <= 1'b1;
            spEn_q   <= 1'b0;
            rdata_q  <= 8'h00;
        end
        else
        begin
            keep_q   <= keepNext;
            ref_q    <= brownoutOnFuse | comparatorBandgapSelect | adcEnable; // [R20]
            spEn_q   <= spEnNext;
            tdoOut_q <= scanTdoData;
            tdoOeN_q <= ~(spEnNext & scanShifting);                     // [R9]
            rdata_q  <= (ioRead && pmcHit) ? pmc_q :
                        (ioRead && rsrHit) ? rsr_q : 8'h00;
        end
    end

    assign sleeping       = sleep_q;
    assign sleepMode      = mode_q;
    assign mainClockKeep  = keep_q;
    assign referenceOn    = ref_q;
    assign scanTdoOut     = tdoOut_q;
    assign scanTdoOeN     = tdoOeN_q;
    assign scanPortEnable = spEn_q;
    assign ioRdata        = rdata_q;
    assign portInitN      = portInit_q;
    assign coreResetN     = portInit_q;
endmodule

//--- hw/rsc_src_combine.sv
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_src_combine
(
    // raw sources
    input  wire logic powerLowN,
    input  wire logic extResetN,
    input  wire logic wdtExpire,
    input  wire logic wdtEnable,
    input  wire logic brownoutLow,
    input  wire logic brownoutOnFuse,
    input  wire logic scanResetReg,
    // combined
    rsc_src_if.gen    src
);
    wire porHit  = ~powerLowN;
    wire extHit  = ~extResetN;
    wire wdtHit  = wdtExpire & wdtEnable;
    wire borHit  = brownoutLow & brownoutOnFuse;
    wire scanHit = scanResetReg;

    assign src.srcHit = {scanHit, wdtHit, borHit, extHit, porHit};
    assign src.anySrc = porHit | extHit | wdtHit | borHit | scanHit;
endmodule

//--- inc/rsc_consts.svh
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// register offsets in the I/O space
`define RSC_PMC_ADDR        6'h35
`define RSC_RSR_ADDR        6'h34
// power management control fields
`define RSC_PMC_SE_BIT      5
`define RSC_PMC_SMLO_HI     4
`define RSC_PMC_SMLO_LO     3
`define RSC_PMC_SMHI_BIT    2
`define RSC_PMC_RESET       8'h00
`define RSC_PMC_WMASK       8'h3C
// reset status fields
`define RSC_RSR_POR_BIT     0
`define RSC_RSR_EXT_BIT     1
`define RSC_RSR_BOR_BIT     2
`define RSC_RSR_WDT_BIT     3
`define RSC_RSR_SCAN_BIT    4
`define RSC_RSR_SPD_BIT     7
`define RSC_RSR_RESET       8'h01
// stretch period defaults, in microseconds, per clock option code
`define RSC_STRETCH_US_SHORT    4
`define RSC_STRETCH_US_LONG     4100
`define RSC_CLK_MHZ             25
`define RSC_STRETCH_CYC_SHORT   (`RSC_STRETCH_US_SHORT * `RSC_CLK_MHZ)
`define RSC_STRETCH_CYC_LONG    (`RSC_STRETCH_US_LONG * `RSC_CLK_MHZ)
// clock option codes at or above this select an external crystal
`define RSC_XTAL_MIN_CODE   4'h8

`endif

//--- inc/rsc_pkg.sv
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_SM_IDLE     = 3'h0,
        RSC_SM_ADCNR    = 3'h1,
        RSC_SM_PDOWN    = 3'h2,
        RSC_SM_PSAVE    = 3'h3,
        RSC_SM_RSV4     = 3'h4,
        RSC_SM_RSV5     = 3'h5,
        RSC_SM_STANDBY  = 3'h6,
        RSC_SM_XSTANDBY = 3'h7
    } rsc_sleep_t;

    typedef enum logic [1:0] {
        RSC_ST_HOLD    = 2'b00,
        RSC_ST_STRETCH = 2'b01,
        RSC_ST_RUN     = 2'b11
    } rsc_rst_state_t;
endpackage

//--- inc/rsc_src_if.sv
`timescale 1ns/1ps
interface rsc_src_if;
    logic       anySrc;
    logic [4:0] srcHit;
    modport gen (output anySrc, output srcHit);
    modport use_ (input anySrc, input srcHit);
endinterface

//--- test/rsc_core_model.sv
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_core_model
(
    // clock
    input  wire logic       clk,
    // register access
    output logic      [5:0] ioAddr,
    output logic            ioWrite,
    output logic            ioRead,
    output logic      [7:0] ioWdata,
    input  wire logic [7:0] ioRdata,
    output logic            sleepExec
);
    initial {ioAddr, ioWrite, ioRead, ioWdata, sleepExec} = 17'h0_0000;
    // released lines flip so a stale address or datum cannot pass
    task automatic drop();
        ioAddr <= ~ioAddr;
        ioWdata <= ~ioWdata;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        ioAddr <= a;
        ioWdata <= d;
        ioWrite <= 1'b1;
        @(posedge clk);
        ioWrite <= 1'b0;
        drop();
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        ioAddr <= a;
        ioRead <= 1'b1;
        @(posedge clk);
        ioRead <= 1'b0;
        drop();
        #1 d = ioRdata;
    endtask
    task automatic doSleep(input logic [2:0] m, input logic en);
        wr(`RSC_PMC_ADDR, {2'b00, en, m[1:0], m[2], 2'b00});
        sleepExec <= 1'b1;
        @(posedge clk);
        sleepExec <= 1'b0;
    endtask
endmodule

//--- test/rsc_properties.sv
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_properties
#(
    parameter int STRETCH_LONG  = `RSC_STRETCH_CYC_LONG,
    parameter int STRETCH_SHORT = `RSC_STRETCH_CYC_SHORT
)
(
    // clock, reset
    input wire logic       clk,
    input wire logic       resetn,
    // sources, fuses
    input wire logic       extResetN,
    input wire logic       wdtExpire,
    input wire logic       wdtEnable,
    input wire logic       brownoutLow,
    input wire logic       brownoutOnFuse,
    input wire logic       scanResetReg,
    input wire logic [3:0] clockOptionFuses,
    input wire logic       scanPortFuse,
    // core side
    input wire logic [5:0] ioAddr,
    input wire logic       ioWrite,
    input wire logic [7:0] ioWdata,
    input wire logic       sleepExec,
    input wire logic       scanShifting,
    // results
    input wire logic       scanTdoOeN,
    input wire logic       scanPortEnable,
    input wire logic       coreResetN,
    input wire logic       portInitN,
    input wire logic       sleeping,
    input wire logic [2:0] sleepMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire        srcOn = !extResetN || scanResetReg || (brownoutLow && brownoutOnFuse);
    wire        wdtHit = wdtExpire && wdtEnable;
    wire        xtal = clockOptionFuses >= `RSC_XTAL_MIN_CODE;
    logic [7:0] pmc_q;
    int         idle_q;
    // shadow of the mode register, so sleep entry can be judged from ports alone
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) pmc_q <= 8'h00;
        else if (!coreResetN) pmc_q <= 8'h00;
        else if (ioWrite && ioAddr == `RSC_PMC_ADDR) pmc_q <= ioWdata & `RSC_PMC_WMASK;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) idle_q <= 0;
        else idle_q <= (srcOn || wdtHit) ? 0 : idle_q + 1;
    property p_extForce; !extResetN |-> !coreResetN; endproperty
    property p_portInit; portInitN == coreResetN; endproperty
    property p_stretch;
        $rose(coreResetN) |-> idle_q >= (xtal ? STRETCH_LONG : STRETCH_SHORT);
    endproperty
    property p_wdt; wdtHit && coreResetN |=> !coreResetN; endproperty
    property p_noEnable; sleepExec && !pmc_q[5] && !sleeping |=> !sleeping; endproperty
    property p_mode;
        $rose(sleeping) |-> $past(sleepExec) && sleepMode == {pmc_q[2], pmc_q[4:3]};
    endproperty
    property p_legal;
        $rose(sleeping) |-> !(sleepMode inside {3'h4, 3'h5}) && (sleepMode < 3'h6 || xtal);
    endproperty
    property p_tdoFloat; !scanShifting ##1 !scanShifting |-> scanTdoOeN; endproperty
    property p_scanOff; !scanPortFuse ##1 !scanPortFuse |-> !scanPortEnable; endproperty
    a_extForce: assert property (p_extForce) else $error("pin low without reset");
    a_portInit: assert property (p_portInit) else $error("port init split");
    a_stretch: assert property (p_stretch) else $error("reset released early");
    a_wdt: assert property (p_wdt) else $error("watchdog reset missing");
    a_noEnable: assert property (p_noEnable) else $error("slept while disabled");
    a_mode: assert property (p_mode) else $error("wrong sleep mode");
    a_legal: assert property (p_legal) else $error("illegal mode entered");
    a_tdoFloat: assert property (p_tdoFloat) else $error("data out driven idle");
    a_scanOff: assert property (p_scanOff) else $error("scan port on unfused");
    c_sleep: cover property ($rose(sleeping));
    c_release: cover property ($rose(coreResetN));
    c_wdt: cover property (wdtHit && coreResetN);
endmodule
bind rsc_reset_sleep_control rsc_properties #(
    .STRETCH_LONG(STRETCH_LONG), .STRETCH_SHORT(STRETCH_SHORT)
) chk (
    .clk, .resetn, .extResetN, .wdtExpire, .wdtEnable, .brownoutLow, .brownoutOnFuse,
    .scanResetReg, .clockOptionFuses, .scanPortFuse, .ioAddr, .ioWrite, .ioWdata,
    .sleepExec, .scanShifting, .scanTdoOeN, .scanPortEnable, .coreResetN, .portInitN,
    .sleeping, .sleepMode
);

//--- test/rsc_reset_sleep_control_tb.sv
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_reset_sleep_control_tb;
    typedef struct packed {logic en; logic [2:0] mode; logic [3:0] opt; logic slp;} rsc_row_t;
    logic       clk, resetn, extResetN, wdtExpire, wdtEnable, brownoutLow, scanResetReg;
    logic       brownoutOnFuse, scanPortFuse, comparatorBandgapSelect, adcEnable, scanShifting;
    logic       ioWrite, ioRead, sleepExec, scanTdoOut, scanTdoOeN, scanPortEnable;
    logic       coreResetN, portInitN, sleeping, mainClockKeep, referenceOn;
    logic       debugKeepClockFuse, scanTdoData;
    logic [3:0] clockOptionFuses;
    logic [5:0] ioAddr;
    logic [7:0] ioWdata, ioRdata, d;
    logic [2:0] sleepMode;
    int         mismatches, checkCount;
    rsc_row_t   rows [11] = '{'{1'b1, 3'h0, 4'h8, 1'b1}, '{1'b1, 3'h1, 4'h8, 1'b1},
        '{1'b1, 3'h2, 4'h8, 1'b1}, '{1'b1, 3'h3, 4'h8, 1'b1}, '{1'b1, 3'h4, 4'h8, 1'b0},
        '{1'b1, 3'h5, 4'h8, 1'b0}, '{1'b1, 3'h6, 4'h8, 1'b1}, '{1'b1, 3'h7, 4'h8, 1'b1},
        '{1'b1, 3'h6, 4'h4, 1'b0}, '{1'b1, 3'h7, 4'h4, 1'b0}, '{1'b0, 3'h2, 4'h8, 1'b0}};
    rsc_reset_sleep_control #(.STRETCH_LONG(20), .STRETCH_SHORT(5)) dut (.clk, .resetn,
        .extResetN, .wdtExpire, .wdtEnable, .brownoutLow, .scanResetReg, .brownoutOnFuse,
        .clockOptionFuses, .debugKeepClockFuse, .scanPortFuse, .ioAddr, .ioWrite,
        .ioRead, .ioWdata, .ioRdata, .sleepExec, .comparatorBandgapSelect, .adcEnable,
        .scanShifting, .scanTdoData, .scanTdoOut, .scanTdoOeN, .scanPortEnable,
        .coreResetN, .portInitN, .sleeping, .sleepMode, .mainClockKeep, .referenceOn);
    rsc_core_model core (.clk, .ioAddr, .ioWrite, .ioRead, .ioWdata, .ioRdata, .sleepExec);
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic tally_and_finish();
        if (mismatches == 0 && checkCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitRun();
        int n;
        n = 0;
        while (coreResetN !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        #1 chk(8'(coreResetN), 8'h01);
        if (n >= 200) tally_and_finish();
    endtask
    task automatic flag(input logic [7:0] exp);
        core.rd(`RSC_RSR_ADDR, d);
        chk(d, exp);
        core.wr(`RSC_RSR_ADDR, 8'h00);
    endtask
    task automatic pinReset();
        @(posedge clk);
        extResetN <= 1'b0;
        #1 chk(8'(portInitN), 8'h00);
        @(posedge clk);
        extResetN <= 1'b1;
        waitRun();
    endtask
    task automatic pulseWdt(input logic en);
        @(posedge clk);
        wdtEnable <= en;
        wdtExpire <= 1'b1;
        @(posedge clk);
        wdtExpire <= 1'b0;
        #1 chk(8'(coreResetN), 8'(!en));
    endtask
    initial
    begin
        {resetn, wdtExpire, wdtEnable, brownoutLow, scanResetReg, brownoutOnFuse} = 6'h00;
        {comparatorBandgapSelect, adcEnable, scanShifting, extResetN, scanPortFuse} = 5'h03;
        clockOptionFuses = 4'h8;
        {debugKeepClockFuse, scanTdoData} = 2'h3;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        waitRun();
        flag(8'h01);
        core.rd(`RSC_PMC_ADDR, d);
        chk(d, `RSC_PMC_RESET);
        core.wr(`RSC_PMC_ADDR, 8'hFF);
        core.rd(`RSC_PMC_ADDR, d);
        chk(d, 8'h3C);
        foreach (rows[i])
        begin
            @(posedge clk);
            clockOptionFuses <= rows[i].opt;
            core.doSleep(rows[i].mode, rows[i].en);
            @(posedge clk);
            #1 chk(8'(sleeping), 8'(rows[i].slp));
            if (rows[i].slp) chk(8'(sleepMode), 8'(rows[i].mode));
            if (rows[i].slp) chk(8'(mainClockKeep), 8'(rows[i].mode inside {3'h2, 3'h3}));
            pinReset();
        end
        @(posedge clk);
        extResetN <= 1'b0;
        @(posedge clk);
        extResetN <= 1'b1;
        repeat (10) @(posedge clk);
        extResetN <= 1'b0;
        @(posedge clk);
        extResetN <= 1'b1;
        repeat (15) @(posedge clk);
        #1 chk(8'(coreResetN), 8'h00);
        waitRun();
        @(posedge clk);
        debugKeepClockFuse <= 1'b0;
        core.doSleep(3'h2, 1'b1);
        @(posedge clk);
        #1 chk(8'(mainClockKeep), 8'h00);
        pinReset();
        flag(8'h02);
        pulseWdt(1'b0);
        pulseWdt(1'b1);
        waitRun();
        flag(8'h08);
        for (int f = 0; f < 2; f++)
        begin
            @(posedge clk);
            brownoutOnFuse <= f[0];
            brownoutLow <= 1'b1;
            #1 chk(8'(coreResetN), 8'(!f[0]));
            @(posedge clk);
            brownoutLow <= 1'b0;
            waitRun();
        end
        flag(8'h04);
        @(posedge clk);
        scanResetReg <= 1'b1;
        repeat (30) @(posedge clk);
        #1 chk(8'(coreResetN), 8'h00);
        @(posedge clk);
        scanResetReg <= 1'b0;
        waitRun();
        flag(8'h10);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            {brownoutOnFuse, comparatorBandgapSelect, adcEnable} <= k[2:0];
            repeat (2) @(posedge clk);
            #1 chk(8'(referenceOn), 8'(k != 0));
        end
        @(posedge clk);
        scanShifting <= 1'b1;
        scanTdoData <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(8'(scanTdoOeN), 8'h00);
        chk(8'(scanTdoOut), 8'h00);
        @(posedge clk);
        scanShifting <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(8'(scanTdoOeN), 8'h01);
        core.wr(`RSC_RSR_ADDR, 8'h80);
        repeat (2) @(posedge clk);
        #1 chk(8'(scanPortEnable), 8'h00);
        core.wr(`RSC_RSR_ADDR, 8'h00);
        scanPortFuse <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(8'(scanPortEnable), 8'h00);
        @(posedge clk);
        resetn <= 1'b0;
        #1 chk(8'(coreResetN), 8'h00);
        @(posedge clk);
        resetn <= 1'b1;
        waitRun();
        flag(8'h01);
        tally_and_finish();
    end
endmodule
